//--- atc_pkg.sv
// Constants and carrier types for the accumulating timer and edge counter
package atc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned TENTH_STEP_NS  = 100_000_000;
  localparam int unsigned HUNDR_STEP_NS  = 10_000_000;
  localparam int unsigned TENTH_CYCLES   = TENTH_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned HUNDR_CYCLES   = HUNDR_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W          = 23;

  ////////////////////////////////////////////////////////////////////////////
  // Value widths and limits
  localparam int unsigned TCV_W          = 27;
  localparam int unsigned CCV_W          = 14;
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned ADDR_W         = 11;
  localparam logic [TCV_W-1:0] TMR_MAX_TENTH = 27'h5F5E0FF;
  localparam logic [TCV_W-1:0] TMR_MAX_HUNDR = 27'h098967F;
  localparam logic [CCV_W-1:0] CNT_MAX       = 14'h270F;

  ////////////////////////////////////////////////////////////////////////////
  // Word memory map
  localparam int unsigned TMR_NUM_DEF    = 0;
  localparam int unsigned CNT_NUM_DEF    = 0;
  localparam int unsigned CNT_WORD_BASE  = 1000;
  localparam int unsigned TMR_SLOTS      = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [TCV_W-1:0]  TCV_RST    = 27'h0000000;
  localparam logic [CCV_W-1:0]  CCV_RST    = 14'h0000;
  localparam logic [DIV_W-1:0]  DIV_RST    = 23'h000000;
  localparam logic [WORD_W-1:0] WORD_RST   = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timer run state, Gray along clear -> run -> hold
  typedef enum logic [1:0] {
    TS_CLEAR = 2'h0,
    TS_RUN   = 2'h1,
    TS_HOLD  = 2'h3
  } atc_tstate_e;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic             enable;
    logic             reset;
    logic             fast;
    logic [TCV_W-1:0] preset;
  } atc_tmr_ctl_s;

  typedef struct packed {
    logic             count;
    logic             reset;
    logic [CCV_W-1:0] preset;
  } atc_cnt_ctl_s;

  typedef struct packed {
    logic             flag;
    logic             running;
    logic [TCV_W-1:0] value;
  } atc_tmr_stat_s;

  typedef struct packed {
    logic             flag;
    logic [CCV_W-1:0] value;
  } atc_cnt_stat_s;

endpackage : atc_pkg

//--- atc_top.sv
// Accumulating timer and edge counter with word-memory view of current values
//
// Functional notes
// - Timer status flag is on exactly when timer current value is at or above its preset and timer reset is off.
// - The accumulating timer takes two consecutive timer slots, two words for its value.
// - Timer current value is read at the word address equal to the timer number.
// - Dropping the enable stops the timer and keeps its time; raising it resumes from there.
// - Timer reset clears the status flag and sets the current value to zero.
// - Counter adds one on each off-to-on change of its count input while reset is off and below 9999, never on a steady level.
// - While counter reset is on, counter value stays zero and its flag stays off.
// - Counter keeps counting past the preset up to 9999 and holds there until reset.
// - Counter status flag is on whenever its current value is at or above its preset and counter reset is off.
// - Counter current value is read at word address counter number plus 1000.
// - Standard timer steps in tenths of a second up to 9999999.9 seconds.
// - Fast timer steps in hundredths of a second up to 99999.99 seconds.
// - Timer runs only while enabled, holds while disabled, stays cleared while reset is on.
`timescale 1ns/1ps

module atc_top
#(
  parameter int unsigned TENTH_CYCLES = atc_pkg::TENTH_CYCLES,
  parameter int unsigned HUNDR_CYCLES = atc_pkg::HUNDR_CYCLES,
  parameter int unsigned TMR_NUM      = atc_pkg::TMR_NUM_DEF,
  parameter int unsigned CNT_NUM      = atc_pkg::CNT_NUM_DEF
)
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // Timer control from program logic
  input  wire atc_pkg::atc_tmr_ctl_s        tmr_ctl,
  // Counter control from program logic
  input  wire atc_pkg::atc_cnt_ctl_s        cnt_ctl,
  // Word memory read port
  input  wire logic [atc_pkg::ADDR_W-1:0]   word_addr,
  output logic      [atc_pkg::WORD_W-1:0]   word_data,
  output logic                              word_hit,
  // Status
  output atc_pkg::atc_tmr_stat_s            tmr_stat,
  output atc_pkg::atc_cnt_stat_s            cnt_stat
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    atc_pkg::atc_tstate_e              tstate;
    logic [atc_pkg::DIV_W-1:0]         div;
    logic [atc_pkg::TCV_W-1:0]         tcv;
    logic                              tflag;
    logic [atc_pkg::CCV_W-1:0]         ccv;
    logic                              cprev;
    logic                              cflag;
    logic [atc_pkg::WORD_W-1:0]        rdata;
    logic                              rhit;
  } atc_state_s;

  localparam atc_state_s STATE_RST = '{
    tstate: atc_pkg::TS_CLEAR,
    div:    atc_pkg::DIV_RST,
    tcv:    atc_pkg::TCV_RST,
    tflag:  1'b0,
    ccv:    atc_pkg::CCV_RST,
    cprev:  1'b0,
    cflag:  1'b0,
    rdata:  atc_pkg::WORD_RST,
    rhit:   1'b0
  };

  // Word addresses of the two timer slots and the counter
  localparam logic [atc_pkg::ADDR_W-1:0] TMR_LO_ADDR =
    atc_pkg::ADDR_W'(TMR_NUM);
  localparam logic [atc_pkg::ADDR_W-1:0] TMR_HI_ADDR =
    atc_pkg::ADDR_W'(TMR_NUM + atc_pkg::TMR_SLOTS - 1);
  localparam logic [atc_pkg::ADDR_W-1:0] CNT_ADDR    =
    atc_pkg::ADDR_W'(CNT_NUM + atc_pkg::CNT_WORD_BASE);

  // Last divider count of one step, per speed
  localparam logic [atc_pkg::DIV_W-1:0] TENTH_LAST =
    atc_pkg::DIV_W'(TENTH_CYCLES - 1);
  localparam logic [atc_pkg::DIV_W-1:0] HUNDR_LAST =
    atc_pkg::DIV_W'(HUNDR_CYCLES - 1);

  atc_state_s state_r;
  atc_state_s state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Saturating increment of the timer value
  function automatic logic [atc_pkg::TCV_W-1:0] tmr_inc
  (
    input logic [atc_pkg::TCV_W-1:0] v,
    input logic [atc_pkg::TCV_W-1:0] lim
  );
    logic [atc_pkg::TCV_W-1:0] r;
    r = (v >= lim) ? lim : v + 1'b1;
    return r;
  endfunction : tmr_inc

  // Saturating increment of the counter value
  function automatic logic [atc_pkg::CCV_W-1:0] cnt_inc
  (
    input logic [atc_pkg::CCV_W-1:0] v
  );
    logic [atc_pkg::CCV_W-1:0] r;
    r = (v >= atc_pkg::CNT_MAX) ? atc_pkg::CNT_MAX : v + 1'b1;
    return r;
  endfunction : cnt_inc

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [atc_pkg::DIV_W-1:0] step_last;
    logic [atc_pkg::TCV_W-1:0] tmr_lim;
    logic                      cnt_edge;
    step_last = tmr_ctl.fast ? HUNDR_LAST : TENTH_LAST;
    tmr_lim   = tmr_ctl.fast ? atc_pkg::TMR_MAX_HUNDR
                             : atc_pkg::TMR_MAX_TENTH;
    cnt_edge  = cnt_ctl.count & ~state_r.cprev;
    state_nxt = state_r;

    // Accumulating timer; reset dominates the enable
    if (tmr_ctl.reset)
    begin
      state_nxt.tcv    = atc_pkg::TCV_RST;
      state_nxt.div    = atc_pkg::DIV_RST;
      state_nxt.tstate = atc_pkg::TS_CLEAR;
    end
    else if (tmr_ctl.enable)
    begin
      state_nxt.tstate = atc_pkg::TS_RUN;
      // Divider keeps its partial step across a hold so no time is lost
      if (state_r.div >= step_last)
      begin
        state_nxt.div = atc_pkg::DIV_RST;
        state_nxt.tcv = tmr_inc(state_r.tcv, tmr_lim);
      end
      else
      begin
        state_nxt.div = state_r.div + 1'b1;
      end
    end
    else
    begin
      // Enable off: value and divider are left untouched
      case (state_r.tstate)
        atc_pkg::TS_CLEAR: state_nxt.tstate = atc_pkg::TS_CLEAR;
        atc_pkg::TS_RUN:   state_nxt.tstate = atc_pkg::TS_HOLD;
        atc_pkg::TS_HOLD:  state_nxt.tstate = atc_pkg::TS_HOLD;
        default:           state_nxt.tstate = atc_pkg::TS_CLEAR;
      endcase
    end
    // Flag follows the value it is registered with
    state_nxt.tflag = ~tmr_ctl.reset
                    & (state_nxt.tcv >= tmr_ctl.preset);

    // Edge counter; the stored sample is always refreshed, even in reset,
    // so an input held high across reset release is not counted
    state_nxt.cprev = cnt_ctl.count;
    if (cnt_ctl.reset)
    begin
      state_nxt.ccv = atc_pkg::CCV_RST;
    end
    else if (cnt_edge)
    begin
      state_nxt.ccv = cnt_inc(state_r.ccv);
    end
    state_nxt.cflag = ~cnt_ctl.reset
                    & (state_nxt.ccv >= cnt_ctl.preset);

    // Word memory view; low word of the timer at its own number, high word
    // in the following slot
    state_nxt.rhit  = 1'b1;
    if (word_addr == TMR_LO_ADDR)
    begin
      state_nxt.rdata = state_r.tcv[atc_pkg::WORD_W-1:0];
    end
    else if (word_addr == TMR_HI_ADDR)
    begin
      state_nxt.rdata = atc_pkg::WORD_W'(state_r.tcv[atc_pkg::TCV_W-1:atc_pkg::WORD_W]);
    end
    else if (word_addr == CNT_ADDR)
    begin
      state_nxt.rdata = atc_pkg::WORD_W'(state_r.ccv);
    end
    else
    begin
      state_nxt.rdata = atc_pkg::WORD_RST;
      state_nxt.rhit  = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= STATE_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops, except running, which is decoded from the registered run state
  assign word_data        = state_r.rdata;
  assign word_hit         = state_r.rhit;
  assign tmr_stat.flag    = state_r.tflag;
  assign tmr_stat.running = (state_r.tstate == atc_pkg::TS_RUN);
  assign tmr_stat.value   = state_r.tcv;
  assign cnt_stat.flag    = state_r.cflag;
  assign cnt_stat.value   = state_r.ccv;

endmodule : atc_top

//--- atc_prog_model.sv
// Program-logic model that sends count pulses to the edge counter
`timescale 1ns/1ps

module atc_prog_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Request
  input  wire logic        go,
  input  wire logic [13:0] n,
  input  wire logic        slow,
  // Count line
  output logic             count,
  output logic             busy
);
  logic [13:0] left_r;
  logic [1:0]  gap_r;

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      count  <= 1'b0;
      left_r <= 14'h0000;
      gap_r  <= 2'h0;
    end
    else if (go)
      left_r <= n;
    else if (count)
      count <= 1'b0;
    else if (gap_r != 2'h0)
      gap_r <= gap_r - 2'h1;
    else if (left_r != 14'h0000)
    begin
      count  <= 1'b1;
      left_r <= left_r - 14'h0001;
      gap_r  <= {slow, 1'b0};
    end

  assign busy = (left_r != 14'h0000) || count;
endmodule : atc_prog_model

//--- atc_top_chk.sv
// Port checker for the accumulating timer and edge counter
`timescale 1ns/1ps

module atc_top_chk
#(
  parameter int unsigned TMR_NUM = 0,
  parameter int unsigned CNT_NUM = 0
)
(
  // Clock and reset
  input logic                            clk,
  input logic                            resetn,
  // Controls
  input atc_pkg::atc_tmr_ctl_s           tmr_ctl,
  input atc_pkg::atc_cnt_ctl_s           cnt_ctl,
  // Word port
  input logic [atc_pkg::ADDR_W-1:0]      word_addr,
  input logic [atc_pkg::WORD_W-1:0]      word_data,
  input logic                            word_hit,
  // Status
  input atc_pkg::atc_tmr_stat_s          tmr_stat,
  input atc_pkg::atc_cnt_stat_s          cnt_stat
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_TFLAG: assert property ($past(resetn) |->
    tmr_stat.flag == (tmr_stat.value >= $past(tmr_ctl.preset) && !$past(tmr_ctl.reset)))
    else $error("timer flag wrong");
  AST_TRST: assert property (tmr_ctl.reset |=> tmr_stat.value == 0 && !tmr_stat.flag)
    else $error("timer not cleared");
  AST_THOLD: assert property (!tmr_ctl.enable && !tmr_ctl.reset |=> $stable(tmr_stat.value))
    else $error("timer moved while off");
  AST_TSTEP: assert property ($changed(tmr_stat.value) && tmr_stat.value != 0 |->
    $past(tmr_ctl.enable) && tmr_stat.value == $past(tmr_stat.value) + 1)
    else $error("timer step wrong");
  AST_CEDGE: assert property (resetn && $rose(cnt_ctl.count) && !cnt_ctl.reset &&
    cnt_stat.value != atc_pkg::CNT_MAX |=> cnt_stat.value == $past(cnt_stat.value) + 1)
    else $error("edge not counted");
  AST_CSTEADY: assert property (resetn && $past(resetn) && $stable(cnt_ctl.count) |=>
    $stable(cnt_stat.value) || cnt_stat.value == 0)
    else $error("level counted");
  AST_CRST: assert property (cnt_ctl.reset |=> cnt_stat.value == 0 && !cnt_stat.flag)
    else $error("counter not cleared");
  AST_CSAT: assert property (cnt_stat.value == atc_pkg::CNT_MAX && !cnt_ctl.reset |=>
    cnt_stat.value == atc_pkg::CNT_MAX)
    else $error("counter left max");
  AST_CFLAG: assert property ($past(resetn) |->
    cnt_stat.flag == (cnt_stat.value >= $past(cnt_ctl.preset) && !$past(cnt_ctl.reset)))
    else $error("counter flag wrong");
  AST_WTMR: assert property (word_addr == TMR_NUM |=>
    word_hit && word_data == $past(tmr_stat.value[15:0]))
    else $error("timer word wrong");
  AST_WCNT: assert property (word_addr == CNT_NUM + 1000 |=>
    word_hit && word_data == {2'h0, $past(cnt_stat.value)})
    else $error("counter word wrong");

  cover property (tmr_stat.flag);
  cover property (cnt_stat.value == atc_pkg::CNT_MAX);
  cover property ($rose(cnt_ctl.count) && cnt_ctl.reset);
endmodule : atc_top_chk

bind atc_top atc_top_chk #(.TMR_NUM(TMR_NUM), .CNT_NUM(CNT_NUM)) u_atc_top_chk (
  .clk(clk), .resetn(resetn), .tmr_ctl(tmr_ctl), .cnt_ctl(cnt_ctl), .word_addr(word_addr),
  .word_data(word_data), .word_hit(word_hit), .tmr_stat(tmr_stat), .cnt_stat(cnt_stat));

//--- atc_top_test.sv
// Testbench for the accumulating timer and edge counter
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end

module atc_top_test;
  logic                   clk = 1'b0, resetn = 1'b0, t_en = 1'b0, t_rst = 1'b0, t_fast = 1'b0;
  logic                   tc = 1'b0, c_rst = 1'b0, go = 1'b0, slow = 1'b0, pm_count, busy, wh;
  logic [26:0]            t_pre = 27'h0000000;
  logic [13:0]            c_pre = 14'h0000, n = 14'h0000;
  logic [10:0]            wa = 11'h000;
  logic [15:0]            wd;
  int                     errors = 0, n_checks = 0;
  atc_pkg::atc_tmr_ctl_s  tctl;
  atc_pkg::atc_cnt_ctl_s  cctl;
  atc_pkg::atc_tmr_stat_s ts;
  atc_pkg::atc_cnt_stat_s cs;

  assign tctl = {t_en, t_rst, t_fast, t_pre};
  assign cctl = {pm_count | tc, c_rst, c_pre};
  always #10 clk = ~clk;

  // Short divider counts keep the run brief: 4 edges per tenth, 2 per hundredth
  atc_top #(.TENTH_CYCLES(4), .HUNDR_CYCLES(2), .TMR_NUM(3), .CNT_NUM(3)) u_atc_top (
    .clk(clk), .resetn(resetn), .tmr_ctl(tctl), .cnt_ctl(cctl), .word_addr(wa),
    .word_data(wd), .word_hit(wh), .tmr_stat(ts), .cnt_stat(cs));
  atc_prog_model u_atc_prog_model (.clk(clk), .resetn(resetn), .go(go), .n(n),
    .slow(slow), .count(pm_count), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////
  task rd(input logic [10:0] a, input logic [15:0] d, input logic h);
    @(posedge clk);
    wa <= a;
    @(posedge clk);
    #1;
    `CHK(wd, d)
    `CHK(wh, h)
  endtask : rd

  task pulses(input logic [13:0] k, input logic s);
    int i;
    @(posedge clk);
    go <= 1'b1;
    n <= k;
    slow <= s;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (i = 0; i < 30000 && busy; i++) #20;
    // A model that never goes idle counts as a mismatch here
    `CHK(busy, 1'b0)
  endtask : pulses

  task t_timer;
    @(posedge clk);
    t_pre <= 27'h0000005;
    t_en <= 1'b1;
    repeat (8) @(posedge clk);
    t_en <= 1'b0;
    #1 `CHK(ts.value, 27'h0000002)
    repeat (10) @(posedge clk);
    t_en <= 1'b1;
    #1 `CHK(ts.value, 27'h0000002)
    `CHK(ts.flag, 1'b0)
    `CHK(ts.running, 1'b0)
    repeat (12) @(posedge clk);
    t_en <= 1'b0;
    #1 `CHK(ts.value, 27'h0000005)
    `CHK(ts.flag, 1'b1)
    `CHK(ts.running, 1'b1)
    rd(11'h003, 16'h0005, 1'b1);
    rd(11'h004, 16'h0000, 1'b1);
    rd(11'h005, 16'h0000, 1'b0);
    @(posedge clk);
    t_rst <= 1'b1;
    t_en <= 1'b1;
    t_fast <= 1'b1;
    repeat (6) @(posedge clk);
    t_rst <= 1'b0;
    #1 `CHK(ts, '0)
    repeat (6) @(posedge clk);
    #1 `CHK(ts.value, 27'h0000003)
    $display("timer test done");
  endtask : t_timer

  task t_counter;
    @(posedge clk);
    c_pre <= 14'h0003;
    pulses(14'h0002, 1'b0);
    `CHK(cs, {1'b0, 14'h0002})
    @(posedge clk);
    tc <= 1'b1;
    repeat (5) @(posedge clk);
    tc <= 1'b0;
    #1 `CHK(cs, {1'b1, 14'h0003})
    pulses(14'h0001, 1'b1);
    `CHK(cs.value, 14'h0004)
    rd(11'h3EB, 16'h0004, 1'b1);
    @(posedge clk);
    c_rst <= 1'b1;
    pulses(14'h0003, 1'b0);
    `CHK(cs, '0)
    @(posedge clk);
    c_rst <= 1'b0;
    // One pulse beyond the top shows the hold at the maximum
    pulses(14'h2710, 1'b0);
    `CHK(cs, {1'b1, 14'h270F})
    $display("counter test done");
  endtask : t_counter

  ////////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_timer();
    t_counter();
    final_report();
  end

  initial
  begin
    #1_000_000;
    errors++;
    final_report();
  end
endmodule : atc_top_test
